// file: hw/adcseq_top.sv
// conversion sequencer with AXI4-Lite registers, channel scan and interrupt
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "adcseq_defines.svh"
// Behaviour
// R1: fixed-channel repeat raises interrupt every ITM+1 conversions, one to eight.
// R2: interrupt timing field used only with repeat set and scan clear.
// R3: repeat 0 converts once; repeat 1 keeps converting until software stops.
// R4: scan 0 converts a fixed channel; scan 1 scans the channel range.
// R5: clearing only repeat stops a repeat sequence in either mode.
// R6: scan start channel sits in bits 3-0 of the scan register.
// R7: scan range bits 7-4 give channel count minus one.
// R8: scan walks ascending channels from the start for the set count.
// R9: software keeps start plus range at or below channel three.
// R10: status bit 3 reads 1 once a top-priority conversion completes.
// R11: status bit 2 reads 1 while a top-priority conversion runs.
// R12: status bit 1 reads 1 once a normal conversion completes.
// R13: status bit 0 reads 1 while a normal conversion runs.
// R14: status read clears both done flags, busy flags unchanged.
// R15: software clears power-on and reference-current bits before standby.
// R16: channel codes zero to three pick inputs; other codes reserved.
// R17: clearing repeat finishes the running conversion, sets done, then idles; in scan mode the code first finishes the rest of the pass.
// R18: decimation counter restarts with every new conversion sequence.
module adcseq_top #(
   parameter logic [7:0] CONV_CYCLES = `ADCSEQ_CONV_CYCLES
) (
   input  wire logic                     aclk,          // 10 MHz clock
   input  wire logic                     aresetn,       // sync reset, active low
   input  wire adcseq_pkg::adcseq_axi_req_t axi_req,    // AXI4-Lite requests
   output adcseq_pkg::adcseq_axi_rsp_t   axi_rsp,       // AXI4-Lite answers
   input  wire logic                     trig_normal,   // hardware start, normal
   input  wire logic                     trig_priority, // hardware start, priority
   input  wire logic [3:0]               priority_chan, // priority input channel
   output logic [3:0]                    conv_channel,  // channel to the analog mux
   output logic                          conv_start,    // start pulse to the core
   output logic                          converter_power_on,       // core power
   output logic                          reference_current_always, // ref current
   output logic                          idle_operation_enable,    // run when idle
   output logic                          irq            // level interrupt
);
   import adcseq_pkg::*;

   // ==========================================================
   // registers and internal event signals
   logic [31:0]   mode_q;
   logic [31:0]   scan_q;
   logic [31:0]   ctrl_q;
   logic [1:0]    irq_stat_q;
   logic [1:0]    irq_mask_q;
   logic          normal_done_flag_q;
   logic          priority_done_flag_q;
   adcseq_state_t state_q;
   logic [3:0]    chan_q;
   logic [3:0]    left_q;
   logic [2:0]    dec_q;
   logic          resume_q;
   logic          conv_done;
   logic          done_event;
   logic          conv_irq_ev;
   logic          hp_irq_ev;

   // mode and scan fields
   logic       f_scan;
   logic       f_rpt;
   logic [2:0] f_itm;
   logic [3:0] f_start;
   logic [3:0] f_range;
   assign f_scan  = mode_q[`ADCSEQ_MODE_SCAN_BIT];
   assign f_rpt   = mode_q[`ADCSEQ_MODE_RPT_BIT];
   assign f_itm   = mode_q[`ADCSEQ_MODE_ITM_LSB +: 3];
   assign f_start = scan_q[3:0]; // R6
   assign f_range = scan_q[7:4]; // R7

   // ==========================================================
   // AXI4-Lite write side: address and data taken in either order
   logic        aw_held_q;
   logic        w_held_q;
   logic [11:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        wr_fire;
   logic        sw_start;
   logic        sw_hpstart;
   logic [31:0] wmask;
   assign wr_fire = aw_held_q && w_held_q && !axi_rsp.bvalid;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{wstrb_q[i]}};
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q       <= 1'b0;
         w_held_q        <= 1'b0;
         awaddr_q        <= 12'h000;
         wdata_q         <= 32'h0000_0000;
         wstrb_q         <= 4'h0;
         axi_rsp.awready <= 1'b0;
         axi_rsp.wready  <= 1'b0;
         axi_rsp.bvalid  <= 1'b0;
         axi_rsp.bresp   <= `ADCSEQ_RESP_OKAY;
      end else begin
         axi_rsp.awready <= !aw_held_q && !axi_rsp.awready && axi_req.awvalid;
         axi_rsp.wready  <= !w_held_q && !axi_rsp.wready && axi_req.wvalid;
         if (axi_rsp.awready && axi_req.awvalid) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= axi_req.awaddr;
         end
         if (axi_rsp.wready && axi_req.wvalid) begin
            w_held_q <= 1'b1;
            wdata_q  <= axi_req.wdata;
            wstrb_q  <= axi_req.wstrb;
         end
         if (wr_fire) begin
            aw_held_q      <= 1'b0;
            w_held_q       <= 1'b0;
            axi_rsp.bvalid <= 1'b1;
            if (awaddr_q == `ADCSEQ_OFF_MODE || awaddr_q == `ADCSEQ_OFF_SCAN ||
                awaddr_q == `ADCSEQ_OFF_CTRL || awaddr_q == `ADCSEQ_OFF_IRQ_MASK ||
                awaddr_q == `ADCSEQ_OFF_STATUS || awaddr_q == `ADCSEQ_OFF_IRQ_STAT) begin
               axi_rsp.bresp <= `ADCSEQ_RESP_OKAY; // read-only targets ignore data
            end else begin
               axi_rsp.bresp <= `ADCSEQ_RESP_SLVERR;
            end
         end else if (axi_rsp.bvalid && axi_req.bready) begin
            axi_rsp.bvalid <= 1'b0;
         end
      end
   end

   // start bits are self-clearing strobes, never stored
   assign sw_start   = wr_fire && awaddr_q == `ADCSEQ_OFF_CTRL && wstrb_q[0] &&
                       wdata_q[`ADCSEQ_CTRL_START];
   assign sw_hpstart = wr_fire && awaddr_q == `ADCSEQ_OFF_CTRL && wstrb_q[0] &&
                       wdata_q[`ADCSEQ_CTRL_HPSTART];

   // ==========================================================
   // configuration registers, reserved bits held at zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_q     <= `ADCSEQ_RESET_VALUE;
         scan_q     <= `ADCSEQ_RESET_VALUE;
         ctrl_q     <= `ADCSEQ_RESET_VALUE;
         irq_mask_q <= 2'b00;
      end else if (wr_fire) begin
         if (awaddr_q == `ADCSEQ_OFF_MODE) begin
            mode_q <= ((wdata_q & wmask) | (mode_q & ~wmask)) & `ADCSEQ_MODE_MASK;
         end else if (awaddr_q == `ADCSEQ_OFF_SCAN) begin
            scan_q <= ((wdata_q & wmask) | (scan_q & ~wmask)) & `ADCSEQ_SCAN_MASK;
         end else if (awaddr_q == `ADCSEQ_OFF_CTRL) begin
            ctrl_q <= ((wdata_q & wmask) | (ctrl_q & ~wmask)) & `ADCSEQ_CTRL_MASK;
         end else if (awaddr_q == `ADCSEQ_OFF_IRQ_MASK) begin
            irq_mask_q <= wstrb_q[0] ? wdata_q[1:0] : irq_mask_q;
         end
      end
   end

   // ==========================================================
   // read side: one read at a time, data registered
   logic rd_status;
   logic rd_irq_stat;
   assign rd_status   = axi_rsp.arready && axi_req.arvalid &&
                        axi_req.araddr == `ADCSEQ_OFF_STATUS;
   assign rd_irq_stat = axi_rsp.arready && axi_req.arvalid &&
                        axi_req.araddr == `ADCSEQ_OFF_IRQ_STAT;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         axi_rsp.arready <= 1'b0;
         axi_rsp.rvalid  <= 1'b0;
         axi_rsp.rdata   <= 32'h0000_0000;
         axi_rsp.rresp   <= `ADCSEQ_RESP_OKAY;
      end else begin
         axi_rsp.arready <= !axi_rsp.arready && !axi_rsp.rvalid && axi_req.arvalid;
         if (axi_rsp.arready && axi_req.arvalid) begin
            axi_rsp.rvalid <= 1'b1;
            axi_rsp.rresp  <= `ADCSEQ_RESP_OKAY;
            if (axi_req.araddr == `ADCSEQ_OFF_MODE) begin
               axi_rsp.rdata <= mode_q;
            end else if (axi_req.araddr == `ADCSEQ_OFF_SCAN) begin
               axi_rsp.rdata <= scan_q;
            end else if (axi_req.araddr == `ADCSEQ_OFF_STATUS) begin
               axi_rsp.rdata <= {28'h0000000, priority_done_flag_q,     // R10
                                 state_q == ADCSEQ_HPRI,                // R11
                                 normal_done_flag_q,                    // R12
                                 state_q == ADCSEQ_CONV || resume_q};   // R13
            end else if (axi_req.araddr == `ADCSEQ_OFF_CTRL) begin
               axi_rsp.rdata <= ctrl_q;
            end else if (axi_req.araddr == `ADCSEQ_OFF_IRQ_STAT) begin
               axi_rsp.rdata <= {30'h00000000, irq_stat_q};
            end else if (axi_req.araddr == `ADCSEQ_OFF_IRQ_MASK) begin
               axi_rsp.rdata <= {30'h00000000, irq_mask_q};
            end else begin
               axi_rsp.rdata <= 32'h0000_0000;
               axi_rsp.rresp <= `ADCSEQ_RESP_SLVERR;
            end
         end else if (axi_rsp.rvalid && axi_req.rready) begin
            axi_rsp.rvalid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // conversion sequencer; priority requests win over normal ones
   logic hp_req;
   logic nm_req;
   logic seq_more;
   assign hp_req = sw_hpstart || trig_priority;
   assign nm_req = sw_start || trig_normal;
   // another normal conversion follows while a scan pass has channels left, or when repeating
   assign seq_more = (f_scan && left_q != 4'h0) || f_rpt; // R3 R4 R5
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q    <= ADCSEQ_IDLE;
         chan_q     <= 4'h0;
         left_q     <= 4'h0;
         resume_q   <= 1'b0;
         conv_start <= 1'b0;
      end else begin
         conv_start <= 1'b0;
         case (state_q)
            ADCSEQ_IDLE: begin
               if (hp_req) begin
                  state_q    <= ADCSEQ_HPRI;
                  conv_start <= 1'b1;
               end else if (nm_req) begin
                  state_q    <= ADCSEQ_CONV;
                  conv_start <= 1'b1;
                  chan_q     <= f_scan ? f_start : scan_q[3:0]; // R4 R6
                  left_q     <= f_scan ? f_range : 4'h0;        // R7
               end
            end
            ADCSEQ_CONV: begin
               if (conv_done) begin
                  // a cleared repeat ends here, after this conversion (in scan mode, the last of the pass) completes
                  if (hp_req) begin
                     state_q    <= ADCSEQ_HPRI; // normal sequence paused
                     resume_q   <= seq_more;
                     conv_start <= 1'b1;
                  end else if (seq_more) begin // R17
                     conv_start <= 1'b1;
                  end else begin
                     state_q <= ADCSEQ_IDLE;  // R17
                  end
                  if (f_scan) begin
                     if (left_q == 4'h0) begin
                        chan_q <= f_start;      // R8
                        left_q <= f_range;
                     end else begin
                        chan_q <= chan_q + 4'h1; // R8
                        left_q <= left_q - 4'h1;
                     end
                  end
               end
            end
            ADCSEQ_HPRI: begin
               if (conv_done) begin
                  state_q    <= resume_q ? ADCSEQ_CONV : ADCSEQ_IDLE;
                  conv_start <= resume_q;
                  resume_q   <= 1'b0;
               end
            end
            default: state_q <= ADCSEQ_IDLE;
         endcase
      end
   end

   adcseq_conv_timer #(
      .CYCLES (CONV_CYCLES)
   ) u_timer (
      .aclk    (aclk),
      .aresetn (aresetn),
      .start   (conv_start),
      .done    (conv_done)
   );

   // mux select is launched with conv_start; reserved codes clamp
   logic [3:0] nm_chan;
   assign nm_chan = (state_q == ADCSEQ_IDLE) ? (f_scan ? f_start : scan_q[3:0]) :
                    (!f_scan || state_q != ADCSEQ_CONV) ? chan_q :
                    (left_q == 4'h0) ? f_start : chan_q + 4'h1;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         conv_channel <= 4'h0;
      end else if (hp_req && state_q != ADCSEQ_HPRI &&
                   (state_q == ADCSEQ_IDLE || conv_done)) begin
         conv_channel <= (priority_chan > `ADCSEQ_LAST_CHANNEL) ? 4'h0 : priority_chan;
      end else if (state_q == ADCSEQ_IDLE || conv_done) begin
         conv_channel <= (nm_chan > `ADCSEQ_LAST_CHANNEL) ? 4'h0 : nm_chan; // R16 R9
      end
   end

   // ==========================================================
   // done flags: set wins over the clear of a status read
   assign done_event = conv_done && state_q == ADCSEQ_CONV;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         normal_done_flag_q   <= 1'b0;
         priority_done_flag_q <= 1'b0;
      end else begin
         if (done_event) begin
            normal_done_flag_q <= 1'b1;                 // R12
         end else if (rd_status) begin
            normal_done_flag_q <= 1'b0;                 // R14
         end else if (state_q == ADCSEQ_IDLE && nm_req && !hp_req) begin
            normal_done_flag_q <= 1'b0;                 // R12
         end
         if (conv_done && state_q == ADCSEQ_HPRI) begin
            priority_done_flag_q <= 1'b1;               // R10
         end else if (rd_status) begin
            priority_done_flag_q <= 1'b0;               // R14
         end else if (state_q == ADCSEQ_IDLE && hp_req) begin
            priority_done_flag_q <= 1'b0;               // R10
         end
      end
   end

   // ==========================================================
   // interrupt decimation, only in fixed-channel repeat
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dec_q <= 3'h0;
      end else if (state_q == ADCSEQ_IDLE && nm_req && !hp_req) begin
         dec_q <= 3'h0;                                 // R18
      end else if (done_event && f_rpt && !f_scan) begin
         dec_q <= (dec_q == f_itm) ? 3'h0 : dec_q + 3'h1; // R1
      end
   end
   // scan: interrupt at end of each pass; single: every conversion
   assign conv_irq_ev = done_event && ((f_rpt && !f_scan) ? (dec_q == f_itm) : // R1 R2
                                       (f_scan ? left_q == 4'h0 : 1'b1));
   assign hp_irq_ev   = conv_done && state_q == ADCSEQ_HPRI;

   // sticky status cleared by reading it; new events win
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_q <= 2'b00;
         irq        <= 1'b0;
      end else begin
         irq_stat_q <= (rd_irq_stat ? 2'b00 : irq_stat_q) | {hp_irq_ev, conv_irq_ev};
         irq        <= |(irq_stat_q & irq_mask_q);
      end
   end

   // power controls are plain register bits for software
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         converter_power_on       <= 1'b0;
         idle_operation_enable    <= 1'b0;
         reference_current_always <= 1'b0;
      end else begin
         converter_power_on       <= ctrl_q[7]; // R15
         idle_operation_enable    <= ctrl_q[6];
         reference_current_always <= ctrl_q[5]; // R15
      end
   end
endmodule // adcseq_top

// file: hw/adcseq_defines.svh
// register offsets, field positions, reset values and counts for the conversion sequencer
`ifndef ADCSEQ_DEFINES_SVH
`define ADCSEQ_DEFINES_SVH
`define ADCSEQ_OFF_MODE      12'h000
`define ADCSEQ_OFF_SCAN      12'h004
`define ADCSEQ_OFF_STATUS    12'h008
`define ADCSEQ_OFF_CTRL      12'h00C
`define ADCSEQ_OFF_IRQ_STAT  12'h010
`define ADCSEQ_OFF_IRQ_MASK  12'h014
`define ADCSEQ_MODE_SCAN_BIT 0
`define ADCSEQ_MODE_RPT_BIT  1
`define ADCSEQ_MODE_ITM_LSB  4
`define ADCSEQ_MODE_MASK     32'h0000_0073
`define ADCSEQ_SCAN_MASK     32'h0000_00FF
`define ADCSEQ_CTRL_MASK     32'h0000_00E0
`define ADCSEQ_CTRL_START    0
`define ADCSEQ_CTRL_HPSTART  1
`define ADCSEQ_IRQ_MASK_BITS 32'h0000_0003
`define ADCSEQ_RESET_VALUE   32'h0000_0000
`define ADCSEQ_LAST_CHANNEL  4'h3
`define ADCSEQ_CONV_CYCLES   8'h10
`define ADCSEQ_RESP_OKAY     2'b00
`define ADCSEQ_RESP_SLVERR   2'b10
`endif

// file: hw/adcseq_pkg.sv
// types shared by the conversion sequencer
package adcseq_pkg;
   typedef struct packed {
      logic        awvalid;
      logic [11:0] awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [11:0] araddr;
      logic        rready;
   } adcseq_axi_req_t;
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } adcseq_axi_rsp_t;
   typedef enum logic [1:0] {
      ADCSEQ_IDLE = 2'b00,
      ADCSEQ_CONV = 2'b01,
      ADCSEQ_HPRI = 2'b10
   } adcseq_state_t;
endpackage

// file: hw/adcseq_conv_timer.sv
// conversion time counter: stands in for the analog core's conversion time
`timescale 1ns/1ps
module adcseq_conv_timer #(
   parameter logic [7:0] CYCLES = 8'h10
) (
   input  wire logic aclk,     // clock
   input  wire logic aresetn,  // sync reset, active low
   input  wire logic start,    // begin one conversion
   output logic      done      // one-cycle pulse at end
);
   logic [7:0] cnt_q;
   logic       run_q;
   // ==========================================================
   // down counter, done fires on the last count
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= 8'h00;
         run_q <= 1'b0;
         done  <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            cnt_q <= CYCLES - 8'h01;
            run_q <= 1'b1;
         end else if (run_q) begin
            if (cnt_q == 8'h00) begin
               run_q <= 1'b0;
               done  <= 1'b1;
            end else begin
               cnt_q <= cnt_q - 8'h01;
            end
         end
      end
   end
endmodule // adcseq_conv_timer

// file: verif/adcseq_core_model.sv
// behavioural model of the analog core behind the input multiplexer
`timescale 1ns/1ps
module adcseq_core_model #(
   parameter int CONV = 4
) (
   input  wire logic       aclk,         // clock
   input  wire logic       conv_start,   // start pulse from the sequencer
   input  wire logic [3:0] conv_channel, // multiplexer select
   output logic            smp_valid,    // one-cycle result strobe
   output logic [3:0]      smp_chan      // input that was converted
);
   int cnt_q = 0;
   // ==========================================
   // sample the mux at start, report after the conversion time
   always_ff @(posedge aclk) begin
      smp_valid <= 1'b0;
      if (conv_start) begin
         smp_chan <= conv_channel;
         cnt_q    <= CONV;
      end else if (cnt_q > 0) begin
         cnt_q     <= cnt_q - 1;
         smp_valid <= (cnt_q == 1);
      end else begin
         smp_chan <= ~smp_chan; // meaningless between results, so it toggles
      end
   end
endmodule // adcseq_core_model

// file: verif/adcseq_top_properties.sv
// protocol and behaviour checker for the conversion sequencer ports
`timescale 1ns/1ps
module adcseq_top_properties
   import adcseq_pkg::*;
#(
   parameter logic [7:0] CONV_CYCLES = 8'h10
) (
   input wire logic            aclk,                     // clock
   input wire logic            aresetn,                  // sync reset, active low
   input wire adcseq_axi_req_t axi_req,                  // bus requests
   input wire adcseq_axi_rsp_t axi_rsp,                  // bus answers
   input wire logic            trig_normal,              // normal trigger
   input wire logic            trig_priority,            // priority trigger
   input wire logic [3:0]      priority_chan,            // priority channel
   input wire logic [3:0]      conv_channel,             // mux select
   input wire logic            conv_start,               // start pulse
   input wire logic            converter_power_on,       // core power
   input wire logic            reference_current_always, // ref current
   input wire logic            idle_operation_enable,    // run when idle
   input wire logic            irq                       // interrupt
);
   logic [11:0] rd_addr_q;
   // ==========================================
   // remember which register the pending read targets
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_addr_q <= 12'h000;
      end else if (axi_req.arvalid && axi_rsp.arready) begin
         rd_addr_q <= axi_req.araddr;
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_chan_legal: assert property (conv_start |-> conv_channel <= 4'h3)
      else $error("conversion started on a reserved channel");
   a_start_spacing: assert property (conv_start |=> !conv_start [*3])
      else $error("conversion restarted before the previous one ended");
   a_rdata_hold: assert property (axi_rsp.rvalid && !axi_req.rready
      |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
      else $error("read answer dropped or changed before it was taken");
   a_bvalid_hold: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid)
      else $error("write answer dropped before it was taken");
   a_read_answer: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
      else $error("read answer late");
   a_write_answer: assert property (axi_req.awvalid && axi_rsp.awready |-> ##[1:4] axi_rsp.bvalid)
      else $error("write answer late");
   a_unmapped_err: assert property (axi_req.arvalid && axi_rsp.arready && axi_req.araddr >= 12'h018
      |=> axi_rsp.rresp == 2'b10 && axi_rsp.rdata == 32'h0000_0000)
      else $error("unmapped read not refused");
   a_status_layout: assert property (axi_rsp.rvalid && rd_addr_q == 12'h008
      |-> axi_rsp.rdata[31:4] == 28'h000_0000)
      else $error("status upper bits not zero");
   a_mode_layout: assert property (axi_rsp.rvalid && rd_addr_q == 12'h000
      |-> (axi_rsp.rdata & 32'hFFFF_FF8C) == 32'h0000_0000)
      else $error("mode register reserved bits not zero");
   c_start: cover property (conv_start);
   c_irq: cover property ($rose(irq));
   c_refused: cover property (axi_rsp.rvalid && axi_rsp.rresp == 2'b10);
endmodule // adcseq_top_properties
bind adcseq_top adcseq_top_properties #(.CONV_CYCLES(CONV_CYCLES)) u_props (.aclk, .aresetn,
   .axi_req, .axi_rsp, .trig_normal, .trig_priority, .priority_chan, .conv_channel,
   .conv_start, .converter_power_on, .reference_current_always, .idle_operation_enable, .irq);

// file: verif/test_adcseq_top.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module test_adcseq_top;
   import adcseq_pkg::*;
   localparam int CONV = 4; // shortened conversion time keeps the run brief
   logic            aclk = 1'b0;
   logic            aresetn = 1'b0;
   adcseq_axi_req_t req = '0;
   adcseq_axi_rsp_t rsp;
   logic            trig_n = 1'b0;
   logic            trig_p = 1'b0;
   logic [3:0]      pchan = 4'h3;
   logic [3:0]      chan, smp_c, c;
   logic            start, pwr, refc, idl, irq, smp_v;
   int              bad_count = 0, compares = 0, cycles = 0, nsmp = 0, nstart = 0;
   logic [31:0]     seed = 32'h97BC27DF;
   logic [3:0]      exp_chan[$];
   logic [65:0]     exp_rd[$]; // response, mask, value
   logic [65:0]     e;
   adcseq_top #(.CONV_CYCLES(8'h04)) dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
      .axi_rsp(rsp), .trig_normal(trig_n), .trig_priority(trig_p), .priority_chan(pchan),
      .conv_channel(chan), .conv_start(start), .converter_power_on(pwr),
      .reference_current_always(refc), .idle_operation_enable(idl), .irq(irq));
   adcseq_core_model #(.CONV(CONV)) core (.aclk(aclk), .conv_start(start),
      .conv_channel(chan), .smp_valid(smp_v), .smp_chan(smp_c));
   always #50 aclk = ~aclk;
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(string what, logic [31:0] seen, logic [31:0] want);
      compares++;
      if (seen !== want) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic stop_test();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ==========================================
   // bus master tasks: valid and payload held until each ready edge
   task automatic wr(logic [11:0] a, logic [31:0] d);
      @(posedge aclk);
      req.awvalid <= 1'b1;
      req.awaddr  <= a;
      req.wvalid  <= 1'b1;
      req.wdata   <= d;
      req.wstrb   <= 4'hF;
      req.bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end while (rsp.bvalid !== 1'b1);
      chk("write resp", rsp.bresp, 2'b00);
      req.bready <= 1'b0;
   endtask
   task automatic rd(logic [11:0] a, logic [31:0] v, logic [31:0] m = 32'hFFFF_FFFF,
                     logic [1:0] r = 2'b00);
      @(posedge aclk);
      exp_rd.push_back({r, m, v});
      req.arvalid <= 1'b1;
      req.araddr  <= a;
      req.rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (rsp.arready) req.arvalid <= 1'b0;
      end while (rsp.rvalid !== 1'b1);
      req.rready <= 1'b0;
   endtask
   task automatic wait_smp(int n);
      n += nsmp;
      while (nsmp < n) @(posedge aclk);
      repeat (3) @(posedge aclk);
   endtask
   // ==========================================
   // watcher: each result takes the oldest note off its queue
   always @(posedge aclk) begin
      cycles++;
      if (start === 1'b1) nstart++;
      if (smp_v === 1'b1) begin
         nsmp++;
         if (exp_chan.size() == 0) chk("extra conversion", 1, 0);
         else chk("channel", smp_c, exp_chan.pop_front());
      end
      if (rsp.rvalid === 1'b1 && req.rready && exp_rd.size() > 0) begin
         e = exp_rd.pop_front();
         chk("read data", rsp.rdata & e[63:32], e[31:0]);
         chk("read resp", rsp.rresp, e[65:64]);
      end
      if (cycles == 20000) begin
         bad_count++;
         stop_test();
      end
   end
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd(12'h000, 32'h0);
      rd(12'h004, 32'h0);
      rd(12'h008, 32'h0);
      rd(12'h018, 32'h0, 32'hFFFF_FFFF, 2'b10);
      wr(12'h00C, 32'hE0);
      repeat (2) @(posedge aclk);
      chk("power bits", {pwr, idl, refc}, 3'b111);
      // fixed single on a random channel, hardware trigger
      c = xs() & 4'h3;
      wr(12'h014, 32'h3);
      wr(12'h004, {28'h0, c});
      wr(12'h000, 32'h0);
      exp_chan.push_back(c);
      trig_n <= 1'b1;
      @(posedge aclk);
      trig_n <= 1'b0;
      wait_smp(1);
      chk("irq", irq, 1);
      rd(12'h008, 32'h2);
      rd(12'h008, 32'h0);
      rd(12'h010, 32'h1, 32'h1);
      repeat (2) @(posedge aclk);
      chk("irq", irq, 0);
      // scan single 1..3 with decimation set, which must not matter here
      wr(12'h004, 32'h21);
      wr(12'h000, 32'h71);
      for (int k = 1; k < 4; k++) exp_chan.push_back(k[3:0]);
      wr(12'h00C, 32'hE1);
      wait_smp(3);
      chk("irq", irq, 1);
      rd(12'h010, 32'h1, 32'h1);
      // fixed repeat for every decimation value, restarted each time
      for (int i = 0; i < 8; i++) begin
         c = xs() & 4'h3;
         wr(12'h004, {28'h0, c});
         wr(12'h000, {25'h0, i[2:0], 4'h2});
         repeat (14) exp_chan.push_back(c);
         nstart = 0;
         wr(12'h00C, 32'hE1);
         while (irq !== 1'b1) @(posedge aclk);
         chk("starts before irq", nstart, i + 2);
         rd(12'h008, 32'h1, 32'h1);
         wr(12'h000, {25'h0, i[2:0], 4'h0});
         repeat (3 * CONV) @(posedge aclk);
         exp_chan.delete();
         rd(12'h008, 32'h2, 32'h3);
         rd(12'h010, 32'h1, 32'h1);
      end
      // priority conversion with its interrupt masked, then unmasked
      wr(12'h014, 32'h1);
      exp_chan.push_back(pchan);
      trig_p <= 1'b1;
      @(posedge aclk);
      trig_p <= 1'b0;
      wait_smp(1);
      chk("irq masked", irq, 0);
      rd(12'h008, 32'h8, 32'hC);
      rd(12'h008, 32'h0, 32'h8);
      wr(12'h014, 32'h3);
      repeat (2) @(posedge aclk);
      chk("irq", irq, 1);
      rd(12'h010, 32'h2, 32'h2);
      wr(12'h00C, 32'h0);
      repeat (2) @(posedge aclk);
      chk("power bits", {pwr, idl, refc}, 3'b000);
      stop_test();
   end
endmodule // test_adcseq_top
